// *** csp_pkg.sv ***
// Constants and types for the clocked serial shift port
package csp_pkg;

    localparam int DATA_W = 32;
    localparam int IDX_W = 8;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h03;
    localparam logic [IDX_W-1:0] IDX_PFS = 8'h04;
    localparam logic [IDX_W-1:0] IDX_SCR = 8'h05;
    localparam logic [IDX_W-1:0] IDX_SDL = 8'h06;
    localparam logic [IDX_W-1:0] IDX_SDH = 8'h07;
    localparam logic [IDX_W-1:0] IDX_ODC = 8'h0c;
    localparam logic [IDX_W-1:0] IDX_CRL = 8'h25;
    localparam logic [IDX_W-1:0] IDX_START = 8'h40;

    // Reset values
    localparam logic [3:0] PFS_RST = 4'h0;
    localparam logic [3:0] SCR_RST = 4'h0;
    localparam logic [3:0] CRL_RST = 4'h0;
    localparam logic [3:0] ODC_RST = 4'h0;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [2:0] CNT_LAST = 3'h7;

    // Field positions
    localparam int PFS_SO_EN_BIT = 0;
    localparam int PFS_SI_EN_BIT = 1;
    localparam int CRL_RANGE_BIT = 0;
    localparam int CRL_IDLE_BIT = 1;
    localparam int ODC_OPEN_DRAIN_BIT = 0;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_CNT_LSB = 8;

    // Clock source codes of the divider select field
    localparam logic [2:0] SEL_SYSCLK = 3'h6;
    localparam logic [2:0] SEL_EXT = 3'h7;

    // Transmit clock periods in instruction cycles (one hclk each), range bit 0
    localparam int PER_W = 14;
    localparam logic [PER_W-1:0] PER_TAB [0:5] = '{14'h1000, 14'h0400, 14'h0100,
                                                  14'h0040, 14'h0010, 14'h0004};
    localparam logic [PER_W-1:0] PER_SYSCLK = 14'h0002;
    localparam logic [PER_W-1:0] PER_MIN = 14'h0002;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLKWAIT,
        ST_XFER,
        ST_CONT
    } csp_state_t;

    typedef struct packed {
        logic pin_en;
        logic [2:0] clk_sel;
    } csp_scr_t;

endpackage : csp_pkg

// *** csp_shift_port.sv ***
// Clocked serial shift port with AHB-Lite register slave
// Overview of operation
// R1: Eight bits per transfer, one shift register
// R2: Software rewrites control register on mode change
// R3: Clock pin by control, data pins by select
// R4: Shift register written for send, read received
// R5: Data-out level undefined until shifted or idled
// R6: Start clears counter; counter steps rising edges
// R7: Eighth clock or abort: clear, flag, stop
// R8: Divider bits plus range pick 4..8192 cycles
// R9: Reset enters idle; clock edges ignored there
// R10: Start in idle enters clock-wait
// R11: First clock enters transfer or continuous clock
// R12: Control write in clock-wait returns idle
// R13: Transfer ends on eight clocks or start
// R14: External returns clock-wait; internal idles, stops
// R15: Control write in transfer initialises, idles
// R16: Any transfer exit sets done flag
// R17: Continuous state drives clock, no data
// R18: Pin bits 00 give continuous; write exits
// R19: Idle states drive data-out from idle bit
// R20: Pin bits select continuous/transmit/receive/both
// R21: Send LSB first falling, sample rising
// R22: Control write stops clock, clears counter
// R23: Software waits two cycles before start
// R24: Software clears done flag before start
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module csp_shift_port
    import csp_pkg::*;
#(
    parameter int PERIOD_SHIFT = 0
) (
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write strobe
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic sck_i, // Clock pin input
    output logic sck_o, // Clock pin output
    output logic sck_oe, // Clock pin drive enable
    input wire logic si_i, // Data-in pin
    output logic so_o, // Data-out pin
    output logic so_oe // Data-out drive enable
);

    logic wr_pend_reg;
    logic [IDX_W-1:0] widx_reg;
    logic [31:0] hrdata_reg;
    logic [3:0] pfs_reg;
    csp_scr_t scr_reg;
    logic [3:0] crl_reg;
    logic [3:0] odc_reg;
    logic [7:0] shift_reg;
    logic [2:0] cnt_reg;
    logic done_reg;
    csp_state_t state_reg;
    logic [PER_W-1:0] div_reg;
    logic int_clk_reg;
    logic sck_prev_reg;
    logic sck_oe_reg;
    logic so_reg;
    logic so_oe_reg;

    logic acc;
    logic [IDX_W-1:0] aidx;
    logic [31:0] rd_next;
    logic scr_wr, start_op, stat_wr;
    logic ext, int_run;
    logic [PER_W-1:0] per, half;
    logic int_tick, fall, rise, last_rise;
    logic so_next;

    assign acc = hsel & hready & htrans[1];
    assign aidx = haddr[IDX_W+1:2];
    assign scr_wr = wr_pend_reg && (widx_reg == IDX_SCR);
    assign start_op = wr_pend_reg && (widx_reg == IDX_START);
    assign stat_wr = wr_pend_reg && (widx_reg == IDX_STATUS);

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            widx_reg <= '0;
        end else begin
            wr_pend_reg <= acc & hwrite;
            widx_reg <= aidx;
        end
    end

    // Read mux; write-only and unmapped read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (aidx)
            IDX_STATUS: begin
                rd_next[STAT_DONE_BIT] = done_reg;
                rd_next[STAT_STATE_LSB +: 2] = state_reg;
                rd_next[STAT_CNT_LSB +: 3] = cnt_reg;
            end
            IDX_SDL: rd_next[3:0] = shift_reg[3:0]; // R4
            IDX_SDH: rd_next[3:0] = shift_reg[7:4]; // R4
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata_reg <= rd_next;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pfs_reg <= PFS_RST;
            scr_reg <= SCR_RST;
            crl_reg <= CRL_RST;
            odc_reg <= ODC_RST;
        end else if (wr_pend_reg) begin
            if (widx_reg == IDX_PFS) begin
                pfs_reg <= hwdata[3:0]; // R3
            end
            if (widx_reg == IDX_SCR) begin
                scr_reg <= hwdata[3:0]; // R3
            end
            if (widx_reg == IDX_CRL) begin
                crl_reg <= hwdata[3:0];
            end
            if (widx_reg == IDX_ODC) begin
                odc_reg <= hwdata[3:0];
            end
        end
    end

    // Transmit clock source
    assign ext = (scr_reg.clk_sel == SEL_EXT);
    assign int_run = !ext && (state_reg != ST_IDLE) && !scr_wr; // R22

    always_comb begin
        if (scr_reg.clk_sel == SEL_SYSCLK) begin
            per = PER_SYSCLK;
        end else if (scr_reg.clk_sel > 3'h5) begin
            per = PER_SYSCLK;
        end else begin
            per = PER_TAB[scr_reg.clk_sel] << crl_reg[CRL_RANGE_BIT]; // R8
        end
        per = per >> PERIOD_SHIFT;
        if (per < PER_MIN) begin
            per = PER_MIN;
        end
        half = per >> 1;
    end

    // Internal clock divider, idles high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= '0;
            int_clk_reg <= 1'b1;
        end else if (!int_run) begin
            div_reg <= '0;
            int_clk_reg <= 1'b1;
        end else if (int_tick) begin
            div_reg <= '0;
            int_clk_reg <= ~int_clk_reg;
        end else begin
            div_reg <= div_reg + 14'h0001;
        end
    end

    assign int_tick = int_run && (div_reg >= half - 14'h0001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_i;
        end
    end

    // Edge events; external edges are ignored in idle by the state machine
    always_comb begin
        if (ext) begin
            fall = sck_prev_reg & ~sck_i;
            rise = ~sck_prev_reg & sck_i;
        end else begin
            fall = int_tick & int_clk_reg;
            rise = int_tick & ~int_clk_reg;
        end
    end

    assign last_rise = (state_reg == ST_XFER) && rise && (cnt_reg == CNT_LAST);

    // State and bit counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE; // R9
            cnt_reg <= CNT_RST;
        end else if (scr_wr) begin
            state_reg <= ST_IDLE; // R12 R15 R18
            cnt_reg <= CNT_RST; // R22
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_op) begin
                        state_reg <= ST_CLKWAIT; // R10
                        cnt_reg <= CNT_RST; // R6
                    end
                end
                ST_CLKWAIT: begin
                    if (start_op) begin
                        cnt_reg <= CNT_RST; // R6
                    end else if (fall) begin
                        if (!ext && pfs_reg[1:0] == 2'b00) begin
                            state_reg <= ST_CONT; // R11 R18 R20
                        end else begin
                            state_reg <= ST_XFER; // R11
                        end
                    end
                end
                ST_XFER: begin
                    if (start_op) begin
                        state_reg <= ST_CLKWAIT; // R13
                        cnt_reg <= CNT_RST; // R13
                    end else if (last_rise) begin
                        cnt_reg <= CNT_RST; // R7 R13
                        state_reg <= ext ? ST_CLKWAIT : ST_IDLE; // R14
                    end else if (rise) begin
                        cnt_reg <= cnt_reg + 3'h1; // R6
                    end
                end
                ST_CONT: begin
                    state_reg <= ST_CONT; // R17
                end
                default: begin
                    state_reg <= ST_IDLE;
                    cnt_reg <= CNT_RST;
                end
            endcase
        end
    end

    // Done flag; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_reg <= 1'b0;
        end else if (last_rise || ((scr_wr || start_op) && state_reg == ST_XFER)) begin
            done_reg <= 1'b1; // R7 R16 R22
        end else if (stat_wr && !hwdata[STAT_DONE_BIT]) begin
            done_reg <= 1'b0;
        end
    end

    // Shift register: bus write, else shift on rising edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= SHIFT_RST;
        end else if (wr_pend_reg && widx_reg == IDX_SDL) begin
            shift_reg[3:0] <= hwdata[3:0]; // R4
        end else if (wr_pend_reg && widx_reg == IDX_SDH) begin
            shift_reg[7:4] <= hwdata[3:0]; // R4
        end else if (state_reg == ST_XFER && rise && !scr_wr && !start_op) begin
            shift_reg <= {si_i & pfs_reg[PFS_SI_EN_BIT], shift_reg[7:1]}; // R1 R21
        end
    end

    // Data-out level
    always_comb begin
        so_next = so_reg;
        case (state_reg)
            ST_IDLE: so_next = crl_reg[CRL_IDLE_BIT]; // R19
            ST_CLKWAIT: begin
                if (fall && !scr_wr && !start_op) begin
                    so_next = shift_reg[0]; // R11 R21
                end else begin
                    so_next = crl_reg[CRL_IDLE_BIT]; // R19
                end
            end
            ST_XFER: begin
                if (fall) begin
                    so_next = shift_reg[0]; // R21
                end
            end
            ST_CONT: so_next = so_reg; // R17
            default: so_next = so_reg;
        endcase
    end

    // Pin registers; data-out starts low until idled or shifted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            so_reg <= 1'b0; // R5
            so_oe_reg <= 1'b0;
            sck_oe_reg <= 1'b0;
        end else begin
            so_reg <= so_next;
            so_oe_reg <= pfs_reg[PFS_SO_EN_BIT] & ~(odc_reg[ODC_OPEN_DRAIN_BIT] & so_next); // R3
            sck_oe_reg <= scr_reg.pin_en & ~ext; // R3 R17
        end
    end

    assign so_o = so_reg;
    assign so_oe = so_oe_reg;
    assign sck_o = int_clk_reg;
    assign sck_oe = sck_oe_reg;

endmodule : csp_shift_port

// *** csp_partner.sv ***
// External serial device model on the far side of the port
`timescale 1ns/1ps
module csp_partner (
    input wire logic clk, // Sampling clock
    input wire logic sck, // Clock line level
    input wire logic so, // Data from the port
    output logic sck_drv, // Clock driven in external mode
    output logic si // Data to the port
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic [2:0] n = 3'h0;
    logic sck_q = 1'b1;
    initial sck_drv = 1'b1;
    initial si = 1'b0;
    always @(posedge clk) begin
        sck_q <= sck;
        if (sck_q && !sck) si <= tx[n];
        if (!sck_q && sck) begin
            rx <= {so, rx[7:1]};
            n <= n + 3'h1;
            // Data line inverted after the last bit
            if (n == 3'h7) si <= ~si;
        end
    end
    task automatic load(input logic [7:0] d);
        tx = d;
        n = 3'h0;
    endtask : load
    // Clock stands high outside frames
    task automatic pulse(input int cnt);
        repeat (cnt) begin
            repeat (4) @(posedge clk);
            sck_drv <= 1'b0;
            repeat (4) @(posedge clk);
            sck_drv <= 1'b1;
        end
        repeat (4) @(posedge clk);
    endtask : pulse
endmodule : csp_partner

// *** csp_shift_port_assertions.sv ***
// Checker for the serial shift port ports
`timescale 1ns/1ps
module csp_shift_port_assertions
    import csp_pkg::*;
(
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Type
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Write data
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Ready
    input wire logic sck_o, // Clock out
    input wire logic sck_oe, // Clock enable
    input wire logic so_oe // Data enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] ix;
    logic go, wr, pw, ps, sw, cont;
    logic [4:0] n;
    assign ix = haddr[9:2];
    assign go = hsel && htrans[1];
    assign wr = go && hwrite;
    // Falling clock edges since the last start or control write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pw <= 1'b0;
            ps <= 1'b0;
            sw <= 1'b0;
            cont <= 1'b1;
            n <= 5'h0;
        end else begin
            pw <= wr && ix == IDX_PFS;
            ps <= wr && (ix == IDX_START || ix == IDX_SCR);
            sw <= wr && ix == IDX_SCR;
            if (pw) cont <= hwdata[1:0] == 2'h0;
            if (ps) n <= 5'h0;
            else if ($fell(sck_o) && n != 5'h1f) n <= n + 5'h1;
        end
    end
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("slave not ready");
    property p_wo_rd; go && !hwrite && (ix == IDX_PFS || ix == IDX_SCR || ix == IDX_ODC || ix == IDX_CRL)
        |=> hrdata == 32'h0; endproperty
    a_wo_rd: assert property (p_wo_rd) else $error("write-only read not zero");
    property p_sd_rd; go && !hwrite && (ix == IDX_SDL || ix == IDX_SDH) |=> hrdata[31:4] == 28'h0; endproperty
    a_sd_rd: assert property (p_sd_rd) else $error("shift nibble wider than four");
    property p_st_rd; go && !hwrite && ix == IDX_STATUS |=> (hrdata & 32'hfffff8cb) == 32'h0; endproperty
    a_st_rd: assert property (p_st_rd) else $error("status spare bits set");
    property p_rst; $rose(hresetn) |-> !sck_oe && !so_oe && hrdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
    property p_scr; wr && ix == IDX_SCR |-> ##2 sck_o; endproperty
    a_scr: assert property (p_scr) else $error("clock not stopped by control write");
    property p_max8; cont || n <= 5'h8; endproperty
    a_max8: assert property (p_max8) else $error("more than eight clocks");
    property p_pin; sw |=> ##1 sck_oe == ($past(hwdata[3], 2) && $past(hwdata[2:0], 2) != SEL_EXT); endproperty
    a_pin: assert property (p_pin) else $error("clock pin not per control");
    c_fall: cover property ($fell(sck_o));
    c_start: cover property (wr && ix == IDX_START);
    c_abort: cover property (wr && ix == IDX_SCR && n != 5'h0);
endmodule : csp_shift_port_assertions
bind csp_shift_port csp_shift_port_assertions csp_shift_port_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .sck_o(sck_o), .sck_oe(sck_oe), .so_oe(so_oe)
);

// *** testbench.sv ***
// Self-checking bench for the serial shift port
`timescale 1ns/1ps
module testbench
    import csp_pkg::*;
;
    localparam int SH = 1;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic sck_o, sck_oe, so_o, so_oe, sck_drv, si, sck_ln;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    int error_cnt, samples_checked, i, c;
    assign sck_ln = sck_oe ? sck_o : sck_drv;
    csp_shift_port #(.PERIOD_SHIFT(SH)) csp_shift_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sck_i(sck_ln), .sck_o(sck_o),
        .sck_oe(sck_oe), .si_i(si), .so_o(so_o), .so_oe(so_oe));
    csp_partner csp_partner_inst (.clk(hclk), .sck(sck_ln), .so(so_o), .sck_drv(sck_drv), .si(si));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wt;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                error_cnt++;
                complete_run();
            end
            @(posedge hclk);
        end
    endtask : wt
    task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, ix, 2'b00};
        hwrite <= w;
        wt();
        htrans <= 2'b00;
        hwdata <= d;
        wt();
        rd = hrdata;
    endtask : bus
    task automatic rdc(input logic [7:0] ix, input logic [31:0] exp);
        bus(1'b0, ix, 32'h0);
        chk(rd, exp);
    endtask : rdc
    function automatic logic [31:0] st(input int d, input int s);
        return (s << 4) | (d << 2);
    endfunction : st
    task automatic waitdone;
        int k;
        for (k = 0; k < 3000; k++) begin
            bus(1'b0, IDX_STATUS, 32'h0);
            if (rd[2] === 1'b1) break;
        end
        if (k == 3000) begin
            error_cnt++;
            complete_run();
        end
    endtask : waitdone
    // Counts cycles until n falling clock edges were seen
    task automatic falls(input int n, output int cyc);
        int k;
        logic q;
        k = 0;
        cyc = 0;
        q = sck_ln;
        while (k < n) begin
            @(posedge hclk);
            cyc++;
            if (q && !sck_ln) k++;
            q = sck_ln;
            if (cyc > 20000) begin
                error_cnt++;
                complete_run();
            end
        end
    endtask : falls
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(IDX_STATUS, 32'h0);
        rdc(8'h80, 32'h0);
        bus(1'b1, IDX_SCR, 32'hc);
        bus(1'b1, IDX_CRL, 32'h2);
        repeat (2) @(posedge hclk);
        chk({31'h0, so_o}, 32'h1);
        bus(1'b1, IDX_CRL, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, so_o}, 32'h0);
        bus(1'b1, IDX_PFS, 32'h3);
        bus(1'b1, IDX_SCR, 32'hc);
        bus(1'b1, IDX_SDL, 32'h5);
        bus(1'b1, IDX_SDH, 32'ha);
        csp_partner_inst.load(8'h3c);
        bus(1'b1, IDX_STATUS, 32'h0);
        bus(1'b1, IDX_START, 32'h0);
        waitdone();
        rdc(IDX_STATUS, st(1, 0));
        rdc(IDX_SDL, 32'hc);
        rdc(IDX_SDH, 32'h3);
        chk({24'h0, csp_partner_inst.rx}, 32'ha5);
        chk({31'h0, sck_o}, 32'h1);
        for (i = 0; i < 2; i++) begin
            bus(1'b1, IDX_STATUS, 32'h0);
            bus(1'b1, IDX_START, 32'h0);
            falls(3, c);
            bus(1'b1, i ? IDX_START : IDX_SCR, 32'h8);
            rdc(IDX_STATUS, st(1, i));
        end
        bus(1'b1, IDX_STATUS, 32'h0);
        bus(1'b1, IDX_SCR, 32'h8);
        rdc(IDX_STATUS, st(0, 0));
        for (i = 0; i < 12; i++) begin
            bus(1'b1, IDX_SCR, 32'h8 + i % 6);
            bus(1'b1, IDX_CRL, i / 6);
            bus(1'b1, IDX_START, 32'h0);
            falls(1, c);
            falls(1, c);
            chk(c, (PER_TAB[i % 6] << (i / 6)) >> SH);
        end
        bus(1'b1, IDX_SCR, 32'hf);
        bus(1'b1, IDX_STATUS, 32'h0);
        csp_partner_inst.pulse(2);
        rdc(IDX_STATUS, 32'h0);
        bus(1'b1, IDX_SDL, 32'h6);
        bus(1'b1, IDX_SDH, 32'h9);
        csp_partner_inst.load(8'h5a);
        bus(1'b1, IDX_START, 32'h0);
        csp_partner_inst.pulse(8);
        rdc(IDX_STATUS, st(1, 1));
        rdc(IDX_SDL, 32'ha);
        rdc(IDX_SDH, 32'h5);
        chk({24'h0, csp_partner_inst.rx}, 32'h96);
        bus(1'b1, IDX_PFS, 32'h0);
        bus(1'b1, IDX_SCR, 32'hd);
        bus(1'b1, IDX_START, 32'h0);
        falls(12, c);
        bus(1'b0, IDX_STATUS, 32'h0);
        chk({30'h0, rd[5:4]}, 32'h3);
        bus(1'b1, IDX_SCR, 32'hd);
        bus(1'b0, IDX_STATUS, 32'h0);
        chk({30'h0, rd[5:4]}, 32'h0);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rdc(IDX_STATUS, 32'h0);
        complete_run();
    end
endmodule : testbench
